// ---- hw/cpwm_defines.svh ----
// register offsets, field positions, reset values and timing counts of the compare/pwm unit
// assumes an apb slave with 32-bit data, one aligned word per register
// Notes on behaviour
// - compare mode checks the 16-bit compare pair against the first timer every value
// - code 1000 sets pin on match, 1001 clears it; both set the flag
// - mode code 0000 switches the unit off and resets internal state
// - every compare sub-mode sets the interrupt flag on a match
// - writing zero to the control register forces the compare latch low
// - code 1010 only sets the flag, pin is not controlled
// - code 1011 resets first timer, starts conversion if enabled, pin not controlled
// - trigger asserts during the match; timer clears one clock after the next timer tick
// - special event trigger never sets the timer overflow flag
// - removing the match before the next timer tick cancels the timer reset
// - pwm mode drives a pwm waveform with up to 10-bit duty resolution
// - zero control register releases pin back to the port logic
// - in pwm mode the high duty shadow is read-only
// - pwm period is (period+1) times 4 clocks times the prescale value
// - after timer equals period: clear timer, set pin unless duty zero, load shadow
// - second timer postscaler does not affect pwm period
// - duty is low register msbs plus two fraction bits, latched at period end
// - high time is duty times clock period times prescale value
// - duty double-buffered by shadow plus 2-bit latch, no glitches
// - time base is timer count joined with phase or prescaler bits
// - time base equal to buffered duty drives the pin low
// - duty above period leaves the pin unchanged for the period
// - resolution is log2 of 4 times (period+1), 10 bits at 255
// - sleep freezes the second timer and the pwm logic; pwm pin holds its level, compare matches still act
`ifndef CPWM_DEFINES_SVH
`define CPWM_DEFINES_SVH

`define CPWM_OFF_CTRL     12'h000
`define CPWM_OFF_DUTY_LO  12'h004
`define CPWM_OFF_SHADOW   12'h008
`define CPWM_OFF_PERIOD   12'h00C
`define CPWM_OFF_T2CTRL   12'h010
`define CPWM_OFF_STATUS   12'h014

`define CPWM_CTRL_MODE_LSB 0
`define CPWM_CTRL_FRAC_LSB 4
`define CPWM_T2_ON_BIT     2
`define CPWM_T2_PS_LSB     0
`define CPWM_ST_FLAG_BIT   0
`define CPWM_ST_OVF_BIT    1

`define CPWM_CTRL_RESET    8'h00
`define CPWM_PERIOD_RESET  8'hFF
`define CPWM_PHASES        4

`endif

// ---- hw/cpwm_pkg.sv ----
// types of the compare/pwm unit
// assumes the defines header is compiled alongside
package cpwm_pkg;

    typedef enum logic [1:0] {
        CPWM_CLS_OFF,
        CPWM_CLS_CMP,
        CPWM_CLS_PWM,
        CPWM_CLS_RSV
    } cpwm_class_t;

    typedef struct packed {
        logic       drive;
        logic       level;
    } cpwm_pin_t;

    typedef struct packed {
        logic [1:0] frac;
        logic [3:0] mode;
    } cpwm_ctrl_t;

endpackage

// ---- hw/cpwm_unit.sv ----
// compare and pwm unit with apb register access
// assumes the first timer and the converter live outside; pins handled by port logic
//
// The implementer's own choices: the placing of the registers and register access over APB.
`include "cpwm_defines.svh"

module cpwm_unit #(
    parameter int TW = 16
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic [TW-1:0] first_timer,
    input  wire logic          first_timer_tick,
    input  wire logic          adc_enabled,
    input  wire logic          sleep,
    output logic               first_timer_reset,
    output logic               adc_start,
    output logic               special_event,
    output logic               pin_level,
    output logic               pin_drive
);

    logic [7:0]    module_control_reg;
    logic [7:0]    compare_low_duty_msbs;
    logic [7:0]    compare_high_duty_shadow;
    logic [1:0]    frac_latch;
    logic [7:0]    period_register;
    logic [2:0]    second_timer_control;
    logic [7:0]    second_timer_count;
    logic [3:0]    presc;
    logic [1:0]    phase;
    logic          module_interrupt_flag;
    logic          timer_overflow_flag;
    logic          cmp_latch;
    logic          seen_match;
    logic          reset_pending;
    logic          pwm_started;

    wire logic [3:0] mode_select_field = module_control_reg[`CPWM_CTRL_MODE_LSB +: 4];
    wire logic [1:0] duty_fraction_bits = module_control_reg[`CPWM_CTRL_FRAC_LSB +: 2];
    wire cpwm_pkg::cpwm_class_t cls =
        (mode_select_field[3:2] == 2'b11) ? cpwm_pkg::CPWM_CLS_PWM :
        (mode_select_field[3:2] == 2'b10) ? cpwm_pkg::CPWM_CLS_CMP :
        (mode_select_field == 4'h0) ? cpwm_pkg::CPWM_CLS_OFF : cpwm_pkg::CPWM_CLS_RSV;
    wire logic is_cmp = (cls == cpwm_pkg::CPWM_CLS_CMP);
    wire logic is_pwm = (cls == cpwm_pkg::CPWM_CLS_PWM);
    wire logic run    = !sleep;

    wire logic wr  = psel && penable && pwrite;
    wire logic rd_ok;
    wire logic hit_ctrl   = (paddr == `CPWM_OFF_CTRL);
    wire logic hit_duty   = (paddr == `CPWM_OFF_DUTY_LO);
    wire logic hit_shadow = (paddr == `CPWM_OFF_SHADOW);
    wire logic hit_period = (paddr == `CPWM_OFF_PERIOD);
    wire logic hit_t2     = (paddr == `CPWM_OFF_T2CTRL);
    wire logic hit_status = (paddr == `CPWM_OFF_STATUS);
    assign rd_ok = hit_ctrl | hit_duty | hit_shadow | hit_period | hit_t2 | hit_status;

    // compare pair is the shadow (high) and the low duty register
    wire logic [15:0] cmp_pair = {compare_high_duty_shadow, compare_low_duty_msbs};
    wire logic match = is_cmp && (first_timer == cmp_pair[TW-1:0]);
    wire logic first_hit = match && !seen_match;

    // prescaler: 00 -> 1:1, 01 -> 1:4, 1x -> 1:16
    wire logic [1:0] ps_sel = second_timer_control[`CPWM_T2_PS_LSB +: 2];
    wire logic t2_on = second_timer_control[`CPWM_T2_ON_BIT];
    wire logic [3:0] ps_top = (ps_sel == 2'b00) ? 4'h0 : (ps_sel == 2'b01) ? 4'h3 : 4'hF;
    wire logic ps_wrap = (presc == ps_top);
    wire logic phase_wrap = (phase == 2'(`CPWM_PHASES - 1));
    wire logic t2_inc = run && t2_on && phase_wrap && ps_wrap;
    wire logic period_end = t2_inc && (second_timer_count == period_register);
    wire logic [1:0] low_bits = (ps_sel == 2'b00) ? phase :
                                (ps_sel == 2'b01) ? presc[1:0] : presc[3:2];
    wire logic [9:0] time_base = {second_timer_count, low_bits};
    wire logic [9:0] duty_buf  = {compare_high_duty_shadow, frac_latch};
    wire logic [9:0] duty_new  = {compare_low_duty_msbs, duty_fraction_bits};
    // time base steps every clock at 1:1, otherwise with its low prescaler bits
    wire logic tb_step = run && t2_on &&
                         ((ps_sel == 2'b00) ||
                          (phase_wrap && (ps_sel == 2'b01 || presc[1:0] == 2'h3)));
    wire logic [9:0] next_tb = time_base + 10'h001;
    // clear on the edge that brings the time base to the duty, so high time is exact
    wire logic duty_hit = tb_step && (next_tb == duty_buf);

    // pwm phase and prescaler: the 4 clock phases make the 4x in the period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= 2'h0;
            presc <= 4'h0;
        end else if (run && t2_on) begin
            phase <= phase + 2'h1;
            if (phase_wrap) begin
                presc <= ps_wrap ? 4'h0 : presc + 4'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            second_timer_count <= 8'h00;
        end else if (period_end) begin
            second_timer_count <= 8'h00;
        end else if (t2_inc) begin
            second_timer_count <= second_timer_count + 8'h01;
        end
    end

    // register writes; shadow also serves as compare high byte outside pwm
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            module_control_reg    <= `CPWM_CTRL_RESET;
            compare_low_duty_msbs <= 8'h00;
            period_register       <= `CPWM_PERIOD_RESET;
            second_timer_control  <= 3'h0;
        end else if (wr) begin
            if (hit_ctrl)   module_control_reg    <= pwdata[7:0];
            if (hit_duty)   compare_low_duty_msbs <= pwdata[7:0];
            if (hit_period) period_register       <= pwdata[7:0];
            if (hit_t2)     second_timer_control  <= pwdata[2:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_high_duty_shadow <= 8'h00;
            frac_latch               <= 2'h0;
        end else if (is_pwm && period_end) begin
            compare_high_duty_shadow <= duty_new[9:2];
            frac_latch               <= duty_new[1:0];
        end else if (wr && hit_shadow && !is_pwm) begin
            compare_high_duty_shadow <= pwdata[7:0];
        end
    end

    // compare side: one action per first equal timer value
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seen_match    <= 1'b0;
            reset_pending <= 1'b0;
        end else if (!is_cmp) begin
            seen_match    <= 1'b0;
            reset_pending <= 1'b0;
        end else begin
            seen_match <= match;
            if (first_hit && mode_select_field == 4'hB) begin
                reset_pending <= 1'b1;
            end else if (first_timer_tick || !match) begin
                reset_pending <= 1'b0;
            end
        end
    end

    // flag set wins over a software clear in the same cycle
    wire logic flag_clr = wr && hit_status && pwdata[`CPWM_ST_FLAG_BIT];
    wire logic ovf_clr  = wr && hit_status && pwdata[`CPWM_ST_OVF_BIT];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            module_interrupt_flag <= 1'b0;
            timer_overflow_flag   <= 1'b0;
        end else begin
            if (first_hit)
                module_interrupt_flag <= 1'b1;
            else if (flag_clr)
                module_interrupt_flag <= 1'b0;
            if (period_end)
                timer_overflow_flag <= 1'b1;
            else if (ovf_clr)
                timer_overflow_flag <= 1'b0;
        end
    end

    // trigger pulses for the first timer and converter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            special_event     <= 1'b0;
            adc_start         <= 1'b0;
            first_timer_reset <= 1'b0;
        end else begin
            special_event     <= first_hit && mode_select_field == 4'hB;
            adc_start         <= first_hit && mode_select_field == 4'hB && adc_enabled;
            first_timer_reset <= reset_pending && match && first_timer_tick;
        end
    end

    // pin latch and ownership
    wire logic ctrl_zero_wr = wr && hit_ctrl && (pwdata[7:0] == 8'h00);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_latch   <= 1'b0;
            pwm_started <= 1'b0;
        end else if (ctrl_zero_wr || cls == cpwm_pkg::CPWM_CLS_OFF) begin
            cmp_latch   <= 1'b0;
            pwm_started <= 1'b0;
        end else if (is_cmp) begin
            pwm_started <= 1'b0;
            if (first_hit && mode_select_field == 4'h8) cmp_latch <= 1'b1;
            if (first_hit && mode_select_field == 4'h9) cmp_latch <= 1'b0;
        end else if (is_pwm) begin
            if (period_end) begin
                pwm_started <= 1'b1;
                cmp_latch   <= (duty_new != 10'h000);
            end else if (pwm_started && duty_hit) begin
                cmp_latch   <= 1'b0;
            end
        end
    end

    // only set/clear compare and pwm own the pin; 1010/1011 leave it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_drive <= 1'b0;
            pin_level <= 1'b0;
        end else begin
            pin_drive <= (is_cmp && !mode_select_field[1]) || is_pwm;
            pin_level <= cmp_latch;
        end
    end

    // apb: zero wait states; unmapped reads zero with slverr
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !rd_ok;
            prdata  <= 32'h0000_0000;
            if (psel && !penable && !pwrite) begin
                if (hit_ctrl)   prdata <= {24'h0, module_control_reg};
                if (hit_duty)   prdata <= {24'h0, compare_low_duty_msbs};
                if (hit_shadow) prdata <= {24'h0, compare_high_duty_shadow};
                if (hit_period) prdata <= {24'h0, period_register};
                if (hit_t2)     prdata <= {29'h0, second_timer_control};
                if (hit_status) prdata <= {22'h0, second_timer_count,
                                           timer_overflow_flag, module_interrupt_flag};
            end
        end
    end

endmodule

// ---- tb/cpwm_unit_monitor.sv ----
// port-level checker for the compare/pwm unit
// assumes it is bound to every cpwm_unit instance, ports matched by name
`include "cpwm_defines.svh"

module cpwm_monitor (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        adc_enabled,
    input wire logic        sleep,
    input wire logic        adc_start,
    input wire logic        special_event,
    input wire logic        pin_level,
    input wire logic        pin_drive
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire wr_c = psel && penable && pwrite && paddr == `CPWM_OFF_CTRL;
    // two cycles of slack: the write lands at the access edge, the pin register one later
    property p_rdy; psel && !penable |=> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("no answer to setup");
    property p_err; pslverr |-> pready && (paddr[1:0] != 2'h0 || paddr > `CPWM_OFF_STATUS); endproperty
    a_err: assert property (p_err) else $error("error on mapped address");
    property p_adc; adc_start |-> special_event && $past(adc_enabled); endproperty
    a_adc: assert property (p_adc) else $error("conversion start without trigger");
    property p_once; special_event |=> !special_event; endproperty
    a_once: assert property (p_once) else $error("trigger longer than one cycle");
    property p_off; wr_c && pwdata[7:0] == 8'h00 |=> ##[0:2] !pin_drive; endproperty
    a_off: assert property (p_off) else $error("pin kept after clear");
    property p_low; wr_c && pwdata[7:0] == 8'h00 |=> ##[0:2] !pin_level; endproperty
    a_low: assert property (p_low) else $error("latch not low after clear");
    property p_nodrv; wr_c && pwdata[3:1] == 3'h5 |=> ##[0:2] !pin_drive; endproperty
    a_nodrv: assert property (p_nodrv) else $error("pin driven in flag mode");
    property p_drv; wr_c && pwdata[3:1] == 3'h4 |=> ##[0:2] pin_drive; endproperty
    a_drv: assert property (p_drv) else $error("pin not driven in output mode");
    property p_slp; sleep && $past(sleep) && $past(sleep, 2) |-> $stable(pin_level); endproperty
    a_slp: assert property (p_slp) else $error("pin moved in sleep");
    c_se: cover property (special_event && adc_start);
    c_err: cover property (pslverr);
    c_slp: cover property (sleep && pin_drive);
endmodule

bind cpwm_unit cpwm_monitor u_mon (.*);

// ---- tb/cpwm_timer_model.sv ----
// first timer stand-in: counts on a slow pclk-synchronous tick
// assumes the unit shares pclk and presetn
module cpwm_timer_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        first_timer_reset,
    output logic      [15:0] first_timer,
    output logic             first_timer_tick
);
    logic [3:0] div;
    // tick derived from pclk, never a free-running foreign clock
    assign first_timer_tick = (div == 4'hF);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div <= 4'h0;
            first_timer <= 16'h0000;
        end else begin
            div <= div + 4'h1;
            // reset command wins over the increment
            if (first_timer_reset)
                first_timer <= 16'h0000;
            else if (first_timer_tick)
                first_timer <= first_timer + 16'h0001;
        end
    end
endmodule

// ---- tb/test_compare_and_pwm_unit.sv ----
// self-checking bench of the compare/pwm unit over apb
// assumes the timer model as first timer; pin seen directly at the unit ports
`include "cpwm_defines.svh"

module test_compare_and_pwm_unit;
    timeunit 1ns;
    timeprecision 1ns;
    logic        pclk, presetn, psel, penable, pwrite, adc_enabled, sleep, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, first_timer_reset, adc_start, special_event;
    logic        pin_level, pin_drive, first_timer_tick;
    logic [15:0] first_timer, c;
    int          n_errors, comparisons, n_se, n_adc, s0, a0, n, hi, per;
    logic [11:0] ra [5] = '{`CPWM_OFF_CTRL, `CPWM_OFF_DUTY_LO, `CPWM_OFF_SHADOW,
                            `CPWM_OFF_PERIOD, 12'h018};
    logic [31:0] rw [5] = '{32'hFFFFFF3A, 32'hFFFFFFA5, 32'h5A, 32'h3F, 32'h55};
    logic [31:0] re [5] = '{32'h3A, 32'hA5, 32'h5A, 32'h3F, 32'h0};
    // mode, then expected adc start, drive, level, trigger
    logic [7:0]  crow [5] = '{8'h86, 8'h94, 8'hA0, 8'hB9, 8'hB1};

    cpwm_unit dut (.*);
    cpwm_timer_model tmr (.*);

    initial begin
        pclk = 1'h0;
        forever #20 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        n_se <= n_se + 32'(special_event === 1'h1);
        n_adc <= n_adc + 32'(adc_start === 1'h1);
    end

    task automatic final_report();
        $display("errors %0d, comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask
    task automatic guard(input int k);
        if (k >= 600) begin
            n_errors++;
            final_report();
        end
    endtask
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        int k;
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'h1 && k < 600);
        guard(k);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask
    task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] m,
                       input logic [31:0] e);
        apb(a, 1'h0, 32'h0);
        chk(nm, e, rd & m);
    endtask
    task automatic meas();
        n = 0;
        while (pin_level !== 1'h0 && n < 600) begin
            @(posedge pclk);
            n++;
        end
        while (pin_level !== 1'h1 && n < 600) begin
            @(posedge pclk);
            n++;
        end
        guard(n);
        hi = 0;
        while (pin_level === 1'h1 && hi < 600) begin
            @(posedge pclk);
            hi++;
        end
        per = hi;
        while (pin_level !== 1'h1 && per < 600) begin
            @(posedge pclk);
            per++;
        end
        guard(per);
    endtask
    // the first period after a change may be partial, so the second one is judged
    task automatic pwm_chk(input int e_hi, input int e_per);
        meas();
        meas();
        chk("high time", 32'(e_hi), 32'(hi));
        chk("period", 32'(e_per), 32'(per));
    endtask
    task automatic hicnt(input logic [31:0] e);
        repeat (128) @(posedge pclk);
        hi = 0;
        repeat (64) begin
            @(posedge pclk);
            hi += 32'(pin_level === 1'h1);
        end
        chk("high count", e, 32'(hi));
    endtask
    task automatic wait_timer(input logic [15:0] v, input logic eq);
        n = 0;
        while ((first_timer === v) !== eq && n < 600) begin
            @(posedge pclk);
            n++;
        end
        guard(n);
    endtask

    initial begin
        {psel, penable, pwrite, adc_enabled, sleep, paddr, pwdata} = '0;
        {n_errors, comparisons, n_se, n_adc} = '0;
        presetn = 1'h0;
        repeat (6) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        // pin direction is taken as output at the port, so drive is seen directly
        chk("drive", 32'h0, 32'(pin_drive));
        rdc("period", `CPWM_OFF_PERIOD, 32'hFFFFFFFF, 32'hFF);
        for (int i = 0; i < 5; i++) begin
            apb(ra[i], 1'h1, rw[i]);
            rdc("register", ra[i], 32'hFFFFFFFF, re[i]);
            chk("slverr", 32'(i == 4), 32'(err));
        end
        for (int i = 0; i < 5; i++) begin
            adc_enabled <= crow[i][3];
            apb(`CPWM_OFF_CTRL, 1'h1, 32'(crow[i][7:4]));
            c = first_timer + 16'h0008;
            apb(`CPWM_OFF_DUTY_LO, 1'h1, 32'(c[7:0]));
            apb(`CPWM_OFF_SHADOW, 1'h1, 32'(c[15:8]));
            apb(`CPWM_OFF_STATUS, 1'h1, 32'h3);
            s0 = n_se;
            a0 = n_adc;
            wait_timer(c, 1'h1);
            wait_timer(c, 1'h0);
            repeat (3) @(posedge pclk);
            chk("timer", crow[i][0] ? 32'h0 : 32'(c + 16'h1), 32'(first_timer));
            rdc("flags", `CPWM_OFF_STATUS, 32'h3, 32'h1);
            chk("drive", 32'(crow[i][2]), 32'(pin_drive));
            chk("level", 32'(crow[i][1]), 32'(pin_level));
            chk("trigger", 32'(crow[i][0]), 32'(n_se - s0));
            chk("adc start", 32'(crow[i][3]), 32'(n_adc - a0));
        end
        c = first_timer + 16'h0008;
        apb(`CPWM_OFF_DUTY_LO, 1'h1, 32'(c[7:0]));
        wait_timer(c, 1'h1);
        apb(`CPWM_OFF_DUTY_LO, 1'h1, 32'(c[7:0] + 8'h40));
        wait_timer(c, 1'h0);
        repeat (3) @(posedge pclk);
        chk("timer", 32'(c + 16'h1), 32'(first_timer));
        apb(`CPWM_OFF_CTRL, 1'h1, 32'h0);
        apb(`CPWM_OFF_PERIOD, 1'h1, 32'h3);
        apb(`CPWM_OFF_DUTY_LO, 1'h1, 32'h1);
        apb(`CPWM_OFF_T2CTRL, 1'h1, 32'h4);
        apb(`CPWM_OFF_CTRL, 1'h1, 32'h2C);
        pwm_chk(6, 16);
        apb(`CPWM_OFF_SHADOW, 1'h1, 32'h77);
        rdc("shadow", `CPWM_OFF_SHADOW, 32'hFF, 32'h1);
        apb(`CPWM_OFF_T2CTRL, 1'h1, 32'h5);
        pwm_chk(24, 64);
        sleep <= 1'h1;
        repeat (50) @(posedge pclk);
        sleep <= 1'h0;
        pwm_chk(24, 64);
        apb(`CPWM_OFF_DUTY_LO, 1'h1, 32'h0);
        apb(`CPWM_OFF_CTRL, 1'h1, 32'h0C);
        hicnt(32'h0);
        apb(`CPWM_OFF_DUTY_LO, 1'h1, 32'hFF);
        hicnt(32'h40);
        apb(`CPWM_OFF_CTRL, 1'h1, 32'h0);
        repeat (3) @(posedge pclk);
        chk("drive", 32'h0, 32'(pin_drive));
        chk("level", 32'h0, 32'(pin_level));
        final_report();
    end
endmodule
